// ==== hdl/cmsfc_divider.sv ====
// Purpose: Enable pulse divider by a run-time factor
// Assumes: Factor of zero is treated as one
// Notes: Pulse is one clock wide
`timescale 1ns/1ps
`default_nettype none
module cmsfc_divider #(
   parameter int W = 9
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // Source enable and factor
   input wire logic i_en,
   input wire logic i_clear,
   input wire logic [W-1:0] i_factor,
   // Divided pulse
   output logic o_pulse
);
   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic next_pulse;

   always_comb begin
      next_count = count;
      next_pulse = 1'b0;
      if (i_clear) begin
         next_count = '0;
      end else if (i_en) begin
         if (count + W'(1) >= i_factor) begin
            next_count = '0;
            next_pulse = 1'b1;
         end else begin
            next_count = count + W'(1);
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         count <= '0;
         o_pulse <= 1'b0;
      end else begin
         count <= next_count;
         o_pulse <= next_pulse;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/cmsfc_pkg.sv ====
// Purpose: Shared constants for the clock mode select block
// Assumes: Register port with 8-bit data, one register per index
// Notes: Mode codes follow the two-bit request field
package cmsfc_pkg;
   typedef enum logic [1:0] {
      CMSFC_SELF_CLOCKED = 2'h0,
      CMSFC_ENGAGED_INT = 2'h1,
      CMSFC_BYPASSED_EXT = 2'h2,
      CMSFC_ENGAGED_EXT = 2'h3
   } cmsfc_mode_t;
   localparam logic [2:0] CMSFC_ADDR_CTRL1 = 3'h0;
   localparam logic [2:0] CMSFC_ADDR_CTRL2 = 3'h1;
   localparam logic [2:0] CMSFC_ADDR_STAT1 = 3'h2;
   localparam logic [2:0] CMSFC_ADDR_STAT2 = 3'h3;
   localparam int CMSFC_HGO_BIT = 7;
   localparam int CMSFC_RANGE_BIT = 6;
   localparam int CMSFC_REFERENCE_SELECT_BIT = 5;
   localparam int CMSFC_REQ_LSB = 3;
   localparam int CMSFC_MFD_LSB = 4;
   localparam int CMSFC_RFD_LSB = 0;
   localparam logic [7:0] CMSFC_CTRL1_RST = 8'h00;
   localparam logic [7:0] CMSFC_CTRL2_RST = 8'h00;
   localparam int CMSFC_STATUS_DELAY = 4;
   localparam int CMSFC_IREF_DIV = 7;
   localparam int CMSFC_CMP_INT = 8;
   localparam int CMSFC_CMP_EXT_LO = 2;
   localparam int CMSFC_CMP_EXT_HI = 128;
   localparam int CMSFC_P_LO = 64;
   localparam int CMSFC_P_HI = 1;
   localparam int CMSFC_FIXED_FREQ_CLOCK_MIN_RATIO = 4;
   localparam int CMSFC_STARTUP_NS = 10000;
   localparam int CMSFC_CLK_NS = 10;
   localparam int CMSFC_STARTUP_CYC = CMSFC_STARTUP_NS / CMSFC_CLK_NS;
endpackage

// ==== hdl/cmsfc_top.sv ====
// Purpose: Clock mode select, status, output divider and fixed clock
// Assumes: Oscillator clocks arrive as enable pulses on i_ref_clk
// Notes: Lock and loss-of-clock detection live outside this block
// Function
// - Request field selects mode; status reports actual
// - Status updates several cycles after request write
// - First control write locks reference select unless it sets it with an external request
// - Self-clocked request held off during bypass exit
// - Fallback modes until stable/valid conditions hold
// - Internal reference divided by 8 paces comparisons
// - Engaged-external output divides by 2R unlocked
// - Bypassed-external fixed clock equals bus clock
// - Engaged-external fixed clock is reference halved when locked and ratio met
// - Otherwise fixed clock follows bus clock
// - Fixed clock off in internal modes
// - High-gain bit selects high-gain oscillator
// - High gain only effective with reference select
// - High-gain zero selects low-power oscillator
// - Wait oscillator start-up before external switch
// - Codes 00,01,10,11 map to four modes
// - Multiplier N equals 4 plus twice code
// - Divisor R equals two to the code
// - Prescale 64 low range, 1 high range
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module cmsfc_top #(
   parameter int STARTUP_CYC = cmsfc_pkg::CMSFC_STARTUP_CYC
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // Register port
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Source clock enables
   input wire logic i_int_ref_en,
   input wire logic i_ext_ref_en,
   input wire logic i_osc_en,
   input wire logic i_bus_clock_en,
   // Conditions from detectors
   input wire logic i_osc_stable,
   input wire logic i_ext_ref_valid,
   input wire logic i_loss_of_clock_flag,
   input wire logic i_lock,
   input wire logic i_off_state,
   // Oscillator control
   output logic o_osc_amp_enable,
   output logic o_high_gain_select,
   // Clock enables out
   output logic o_generator_output_clock,
   output logic o_fixed_freq_clock,
   output logic o_compare_strobe
);
   ////////////////////////////////////////////////////////////////
   logic [7:0] ctrl1;
   logic [7:0] ctrl2;
   logic first_done;
   logic reference_select_locked;
   logic [7:0] next_ctrl1;
   logic [7:0] next_ctrl2;
   logic next_first_done;
   logic next_reference_select_locked;
   cmsfc_pkg::cmsfc_mode_t mode_actual;
   cmsfc_pkg::cmsfc_mode_t next_mode_actual;
   cmsfc_pkg::cmsfc_mode_t target;
   logic [2:0] settle;
   logic [2:0] next_settle;
   logic [15:0] startup;
   logic [15:0] next_startup;
   logic was_locked;
   logic next_was_locked;
   logic [7:0] next_rdata;
   logic [1:0] mode_request;
   logic reference_select;
   logic [2:0] multiplier_code;
   logic [2:0] divisor_code;
   assign mode_request = ctrl1[cmsfc_pkg::CMSFC_REQ_LSB +: 2];
   assign reference_select = ctrl1[cmsfc_pkg::CMSFC_REFERENCE_SELECT_BIT] & ~reference_select_locked;
   assign multiplier_code = ctrl2[cmsfc_pkg::CMSFC_MFD_LSB +: 3];
   assign divisor_code = ctrl2[cmsfc_pkg::CMSFC_RFD_LSB +: 3];
   function automatic logic [4:0] mult_n(input logic [2:0] code);
      mult_n = 5'h04 + {1'b0, code, 1'b0};
   endfunction
   function automatic logic [7:0] div_r(input logic [2:0] code);
      div_r = 8'h01 << code;
   endfunction
   ////////////////////////////////////////////////////////////////
   // Register writes and the one-shot reference lock
   always_comb begin
      next_ctrl1 = ctrl1;
      next_ctrl2 = ctrl2;
      next_first_done = first_done;
      next_reference_select_locked = reference_select_locked;
      if (i_wr && i_addr == cmsfc_pkg::CMSFC_ADDR_CTRL1) begin
         next_ctrl1 = {i_wdata[7:1], 1'b0};
         if (!first_done) begin
            next_first_done = 1'b1;
            next_reference_select_locked = ~(i_wdata[cmsfc_pkg::CMSFC_REFERENCE_SELECT_BIT]
               & i_wdata[cmsfc_pkg::CMSFC_REQ_LSB + 1]);
         end
      end
      if (i_wr && i_addr == cmsfc_pkg::CMSFC_ADDR_CTRL2) begin
         next_ctrl2 = i_wdata;
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl1 <= cmsfc_pkg::CMSFC_CTRL1_RST;
         ctrl2 <= cmsfc_pkg::CMSFC_CTRL2_RST;
         first_done <= 1'b0;
         reference_select_locked <= 1'b0;
      end else begin
         ctrl1 <= next_ctrl1;
         ctrl2 <= next_ctrl2;
         first_done <= next_first_done;
         reference_select_locked <= next_reference_select_locked;
      end
   end
   ////////////////////////////////////////////////////////////////
   // Oscillator amplifier; gain only matters with reference select
   logic ext_wanted;
   assign ext_wanted = mode_request[1] & reference_select;
   assign o_osc_amp_enable = ext_wanted;
   assign o_high_gain_select = ext_wanted & ctrl1[cmsfc_pkg::CMSFC_HGO_BIT];
   logic ext_ready;
   assign ext_ready = i_ext_ref_valid && startup == 16'h0000;
   ////////////////////////////////////////////////////////////////
   // Mode resolution with fallbacks
   always_comb begin
      target = mode_actual;
      unique case (cmsfc_pkg::cmsfc_mode_t'(mode_request))
         cmsfc_pkg::CMSFC_SELF_CLOCKED: begin
            // Leaving bypass waits for the internal loop to be stable
            if (mode_actual != cmsfc_pkg::CMSFC_BYPASSED_EXT || i_osc_stable) begin
               target = cmsfc_pkg::CMSFC_SELF_CLOCKED;
            end
         end
         cmsfc_pkg::CMSFC_ENGAGED_INT: begin
            target = i_osc_stable ? cmsfc_pkg::CMSFC_ENGAGED_INT
               : cmsfc_pkg::CMSFC_SELF_CLOCKED;
         end
         cmsfc_pkg::CMSFC_BYPASSED_EXT: begin
            target = ext_ready ? cmsfc_pkg::CMSFC_BYPASSED_EXT
               : cmsfc_pkg::CMSFC_SELF_CLOCKED;
         end
         cmsfc_pkg::CMSFC_ENGAGED_EXT: begin
            if (ext_ready && i_loss_of_clock_flag) begin
               target = cmsfc_pkg::CMSFC_BYPASSED_EXT;
            end else if (ext_ready && i_osc_stable) begin
               target = cmsfc_pkg::CMSFC_ENGAGED_EXT;
            end else if (i_osc_stable) begin
               target = cmsfc_pkg::CMSFC_ENGAGED_INT;
            end else begin
               target = cmsfc_pkg::CMSFC_SELF_CLOCKED;
            end
         end
      endcase
   end
   // Status lags the request so software never sees a same-cycle change
   always_comb begin
      next_mode_actual = mode_actual;
      next_settle = settle;
      next_startup = startup;
      next_was_locked = was_locked;
      if (i_wr && i_addr == cmsfc_pkg::CMSFC_ADDR_CTRL1) begin
         next_settle = 3'(cmsfc_pkg::CMSFC_STATUS_DELAY);
      end else if (settle != 3'h0) begin
         next_settle = settle - 3'h1;
      end else begin
         next_mode_actual = target;
      end
      if (!ext_wanted) begin
         next_startup = 16'(STARTUP_CYC);
      end else if (startup != 16'h0000 && i_osc_en) begin
         next_startup = startup - 16'h0001;
      end
      if (mode_actual != cmsfc_pkg::CMSFC_ENGAGED_EXT) begin
         next_was_locked = 1'b0;
      end else if (i_lock) begin
         next_was_locked = 1'b1;
      end
      if (i_wr && i_addr == cmsfc_pkg::CMSFC_ADDR_CTRL2) begin
         next_was_locked = 1'b0; // Relock after multiplier change
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mode_actual <= cmsfc_pkg::CMSFC_SELF_CLOCKED;
         settle <= 3'h0;
         startup <= 16'(STARTUP_CYC);
         was_locked <= 1'b0;
      end else begin
         mode_actual <= next_mode_actual;
         settle <= next_settle;
         startup <= next_startup;
         was_locked <= next_was_locked;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Output clock divider
   logic out_src_en;
   logic [8:0] out_factor;
   always_comb begin
      out_src_en = i_osc_en;
      out_factor = {1'b0, div_r(divisor_code)};
      if (mode_actual == cmsfc_pkg::CMSFC_BYPASSED_EXT) begin
         out_src_en = i_ext_ref_en;
      end else if (mode_actual == cmsfc_pkg::CMSFC_ENGAGED_EXT && !was_locked) begin
         out_factor = {div_r(divisor_code), 1'b0};
      end
      if (i_off_state) begin
         out_src_en = 1'b0;
      end
   end

   cmsfc_divider #(.W(9)) u_out_div (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_en(out_src_en),
      .i_clear(i_off_state),
      .i_factor(out_factor),
      .o_pulse(o_generator_output_clock)
   );

   ////////////////////////////////////////////////////////////////
   // Comparison cycle pacing
   logic int_ref_div7;
   logic cmp_en;
   logic [8:0] cmp_factor;
   logic ext_mode;
   assign ext_mode = mode_actual == cmsfc_pkg::CMSFC_ENGAGED_EXT;

   cmsfc_divider #(.W(3)) u_iref_div (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_en(i_int_ref_en),
      .i_clear(1'b0),
      .i_factor(3'(cmsfc_pkg::CMSFC_IREF_DIV)),
      .o_pulse(int_ref_div7)
   );

   always_comb begin
      cmp_en = i_int_ref_en;
      cmp_factor = 9'(cmsfc_pkg::CMSFC_CMP_INT);
      if (ext_mode) begin
         cmp_en = i_ext_ref_en;
         cmp_factor = ctrl1[cmsfc_pkg::CMSFC_RANGE_BIT] ? 9'(cmsfc_pkg::CMSFC_CMP_EXT_HI)
            : 9'(cmsfc_pkg::CMSFC_CMP_EXT_LO);
      end
      if (i_off_state) begin
         cmp_en = 1'b0;
      end
   end

   cmsfc_divider #(.W(9)) u_cmp_div (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_en(cmp_en),
      .i_clear(i_off_state),
      .i_factor(cmp_factor),
      .o_pulse(o_compare_strobe)
   );

   ////////////////////////////////////////////////////////////////
   // Fixed-frequency clock
   logic ext_half;
   logic [15:0] pn;
   logic ratio_ok;
   logic next_fixed;
   logic fixed_base;
   assign pn = 16'(mult_n(multiplier_code))
      * (ctrl1[cmsfc_pkg::CMSFC_RANGE_BIT] ? 16'(cmsfc_pkg::CMSFC_P_HI) : 16'(cmsfc_pkg::CMSFC_P_LO));
   assign ratio_ok = pn >= 16'(cmsfc_pkg::CMSFC_FIXED_FREQ_CLOCK_MIN_RATIO) * {8'h00, div_r(divisor_code)};

   cmsfc_divider #(.W(2)) u_half_div (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_en(i_ext_ref_en),
      .i_clear(1'b0),
      .i_factor(2'h2),
      .o_pulse(ext_half)
   );

   always_comb begin
      fixed_base = 1'b0;
      unique case (mode_actual)
         cmsfc_pkg::CMSFC_BYPASSED_EXT: fixed_base = i_bus_clock_en;
         cmsfc_pkg::CMSFC_ENGAGED_EXT: begin
            fixed_base = (ratio_ok && i_lock) ? ext_half : i_bus_clock_en;
         end
         cmsfc_pkg::CMSFC_SELF_CLOCKED,
         cmsfc_pkg::CMSFC_ENGAGED_INT: fixed_base = 1'b0;
      endcase
      next_fixed = fixed_base & ~i_off_state;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_fixed_freq_clock <= 1'b0;
      end else begin
         o_fixed_freq_clock <= next_fixed;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read port; the internal divide-by-7 tick is visible for debug
   always_comb begin
      next_rdata = 8'h00;
      if (i_rd) begin
         unique case (i_addr)
            cmsfc_pkg::CMSFC_ADDR_CTRL1: next_rdata = ctrl1;
            cmsfc_pkg::CMSFC_ADDR_CTRL2: next_rdata = ctrl2;
            cmsfc_pkg::CMSFC_ADDR_STAT1: next_rdata = {mode_actual, reference_select_locked, 1'b0,
               i_lock, i_loss_of_clock_flag, i_ext_ref_valid, 1'b0};
            cmsfc_pkg::CMSFC_ADDR_STAT2: next_rdata = {6'h00, int_ref_div7, i_osc_stable};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// ==== testbench/cmsfc_checker.sv ====
// Purpose: Port assertions for the clock mode select block
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Shadows control register one to predict the amplifier state
`timescale 1ns/1ps
`default_nettype none
module cmsfc_checker #(
   parameter int STARTUP_CYC = 4
) (
   // Clock, reset and register port
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   // Sources and conditions
   input wire logic i_bus_clock_en,
   input wire logic i_ext_ref_en,
   input wire logic i_off_state,
   // Design outputs
   input wire logic o_osc_amp_enable,
   input wire logic o_high_gain_select,
   input wire logic o_generator_output_clock,
   input wire logic o_fixed_freq_clock,
   input wire logic o_compare_strobe
);
   logic [7:0] ctrl1, next_ctrl1;
   logic wrote, next_wrote, reference_select_ok, next_reference_select_ok, ctrl1_wr;
   logic [3:0] quiet, next_quiet;
   assign ctrl1_wr = i_wr && i_addr == cmsfc_pkg::CMSFC_ADDR_CTRL1;
   always_comb begin
      next_ctrl1 = ctrl1_wr ? i_wdata : ctrl1;
      next_wrote = wrote | ctrl1_wr;
      // Only the very first write can leave reference select usable
      next_reference_select_ok = (ctrl1_wr && !wrote) ? (i_wdata[5] & i_wdata[4]) : reference_select_ok;
      next_quiet = ctrl1_wr ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl1 <= 8'h00;
         wrote <= 1'b0;
         reference_select_ok <= 1'b0;
         quiet <= 4'h0;
      end else begin
         ctrl1 <= next_ctrl1;
         wrote <= next_wrote;
         reference_select_ok <= next_reference_select_ok;
         quiet <= next_quiet;
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   a_amp_enable: assert property (o_osc_amp_enable == (ctrl1[4] && ctrl1[5] && reference_select_ok))
      else $error("amplifier enable disagrees with first control write");
   a_gain_follow: assert property (o_high_gain_select == (o_osc_amp_enable && ctrl1[7]))
      else $error("high gain select wrong");
   a_gain_ref: assert property (o_high_gain_select |-> reference_select_ok && ctrl1[5])
      else $error("high gain without reference select");
   a_off_quiet: assert property (i_off_state && $past(i_off_state) |-> !o_generator_output_clock)
      else $error("output clock runs in off state");
   // Halved reference passes a divider stage first, so it lags one more cycle
   a_fixed_source: assert property (o_fixed_freq_clock |-> $past(i_bus_clock_en) || $past(i_ext_ref_en, 2))
      else $error("fixed clock edge without source edge");
   a_fixed_internal: assert property (quiet == 4'hf && ctrl1[4:3] == 2'h1 |-> !o_fixed_freq_clock)
      else $error("fixed clock active in internal mode");
   a_rdata_slot: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside read slot");
   a_cmp_single: assert property (o_compare_strobe |=> !o_compare_strobe)
      else $error("comparison cycle too short");
   c_gain: cover property (o_high_gain_select);
   c_fixed_ext: cover property (o_fixed_freq_clock && $past(i_ext_ref_en));
   c_off: cover property (i_off_state && $past(i_off_state));
endmodule
bind cmsfc_top cmsfc_checker #(.STARTUP_CYC(STARTUP_CYC)) cmsfc_checker_inst (.i_ref_clk, .i_rst_b,
   .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_bus_clock_en, .i_ext_ref_en, .i_off_state,
   .o_osc_amp_enable, .o_high_gain_select, .o_generator_output_clock, .o_fixed_freq_clock, .o_compare_strobe);
`default_nettype wire

// ==== testbench/cmsfc_partner.sv ====
// Purpose: Crystal oscillator and fixed clock consumer model
// Assumes: Crystal edges every fifth cycle while amplified
// Notes: No edges at all while the amplifier is off
`timescale 1ns/1ps
`default_nettype none
module cmsfc_partner (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // Crystal side
   input wire logic i_amp_enable,
   output logic o_ext_ref_en,
   // Peripheral side
   input wire logic i_fixed_clk,
   input wire logic i_use_fixed,
   output logic [15:0] o_fixed_count
);
   logic [2:0] phase;
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         phase <= 3'h0;
         o_ext_ref_en <= 1'b0;
         o_fixed_count <= 16'h0000;
      end else begin
         phase <= (i_amp_enable && phase != 3'h4) ? phase + 3'h1 : 3'h0;
         o_ext_ref_en <= i_amp_enable && phase == 3'h4;
         // Consumer takes the fixed clock only while i_use_fixed is set
         if (i_fixed_clk && i_use_fixed) begin
            o_fixed_count <= o_fixed_count + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// ==== testbench/cmsfc_top_bench.sv ====
// Purpose: Self-checking bench for the clock mode select block
// Assumes: Start-up count shortened to 4 oscillator pulses
// Notes: Pulse counts compared with a tolerance of one edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
   checks_done++; \
   if ((a) !== (b)) begin \
      num_errors++; \
      $display("Error %0t: got %0h expected %0h", $time, (a), (b)); \
   end \
end
module cmsfc_top_bench;
   localparam logic [2:0] C1 = cmsfc_pkg::CMSFC_ADDR_CTRL1;
   localparam logic [2:0] C2 = cmsfc_pkg::CMSFC_ADDR_CTRL2;
   localparam logic [2:0] S1 = cmsfc_pkg::CMSFC_ADDR_STAT1;
   localparam logic [2:0] MT[4] = '{3'h0, 3'h0, 3'h2, 3'h1};
   localparam logic [2:0] DT[4] = '{3'h0, 3'h1, 3'h1, 3'h1};
   logic i_ref_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, use_fixed = 1'b0;
   logic i_int_ref_en = 1'b0, i_osc_en = 1'b0, i_bus_clock_en = 1'b0, i_off_state = 1'b0;
   logic i_osc_stable = 1'b0, i_ext_ref_valid = 1'b0, i_loss_of_clock_flag = 1'b0, i_lock = 1'b0;
   logic i_ext_ref_en, o_osc_amp_enable, o_high_gain_select;
   logic o_generator_output_clock, o_fixed_freq_clock, o_compare_strobe;
   logic [2:0] i_addr = 3'h0;
   logic [7:0] i_wdata = 8'h00, o_rdata, r, cyc = 8'h00;
   logic [15:0] fixed_count;
   logic [1:0] prev, rq, old_rq;
   int num_errors = 0, checks_done = 0, d_fix;
   int cnt[6] = '{default: 0};
   int d[6];
   always #5 i_ref_clk = ~i_ref_clk;
   cmsfc_top #(.STARTUP_CYC(4)) cmsfc_top_inst (.i_ref_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
      .o_rdata, .i_int_ref_en, .i_ext_ref_en, .i_osc_en, .i_bus_clock_en, .i_osc_stable, .i_ext_ref_valid,
      .i_loss_of_clock_flag, .i_lock, .i_off_state, .o_osc_amp_enable, .o_high_gain_select,
      .o_generator_output_clock, .o_fixed_freq_clock, .o_compare_strobe);
   cmsfc_partner cmsfc_partner_inst (.i_ref_clk, .i_rst_b, .i_amp_enable(o_osc_amp_enable),
      .o_ext_ref_en(i_ext_ref_en), .i_fixed_clk(o_fixed_freq_clock), .i_use_fixed(use_fixed),
      .o_fixed_count(fixed_count));
   ////////////////////////////////////////////////////////////
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 8'h01;
      i_osc_en <= cyc[0];
      i_bus_clock_en <= cyc[1:0] == 2'h3;
      i_int_ref_en <= cyc % 8'h03 == 8'h00;
      // Non-blocking so a window snapshot at the same edge is race free
      cnt[0] <= cnt[0] + int'(i_osc_en);
      cnt[1] <= cnt[1] + int'(i_bus_clock_en);
      cnt[2] <= cnt[2] + int'(i_int_ref_en);
      cnt[3] <= cnt[3] + int'(i_ext_ref_en);
      cnt[4] <= cnt[4] + int'(o_generator_output_clock);
      cnt[5] <= cnt[5] + int'(o_compare_strobe);
   end
   task automatic idle(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      // Data stands in the cycle after the strobe; take it at its closing edge
      @(posedge i_ref_clk);
      v = o_rdata;
   endtask
   // Edge counts over a window; latency slop is absorbed by near()
   task automatic window(input int n);
      int b[6];
      logic [15:0] bf;
      b = cnt;
      bf = fixed_count;
      idle(n);
      foreach (d[i]) d[i] = cnt[i] - b[i];
      d_fix = int'(fixed_count - bf);
   endtask
   function automatic logic [7:0] c1(input logic hg, rg, rf, input logic [1:0] q);
      return {hg, rg, rf, q, 3'h0};
   endfunction
   function automatic bit near(input int a, input int b);
      return (a - b) <= 1 && (b - a) <= 1;
   endfunction
   function automatic bit half_ok(input logic rg, input logic [2:0] m, input logic [2:0] dv);
      return (rg ? 1 : 64) * (4 + 2 * int'(m)) >= 4 * (1 << dv);
   endfunction
   function automatic logic [1:0] exp_mode(input logic [1:0] q, input logic [1:0] p, input logic st, va, lo);
      case (q)
         2'h0: return (p == 2'h2 && !st) ? 2'h2 : 2'h0;
         2'h1: return st ? 2'h1 : 2'h0;
         2'h2: return va ? 2'h2 : 2'h0;
         default: return (va && lo) ? 2'h2 : ((va && st) ? 2'h3 : (st ? 2'h1 : 2'h0));
      endcase
   endfunction
   task automatic complete_run();
      if (num_errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(27176));
      idle(2);
      i_rst_b <= 1'b1;
      rd(C1, r);
      `CHK(r, 8'h00);
      rd(3'h5, r);
      `CHK(r, 8'h00);
      i_ext_ref_valid <= 1'b1;
      wr(C1, c1(1'b0, 1'b0, 1'b0, 2'h2));
      wr(C1, c1(1'b1, 1'b0, 1'b1, 2'h2));
      idle(40);
      rd(S1, r);
      `CHK({o_osc_amp_enable, r[7:6]}, 3'h0);
      // Second reset mid-run restores a fresh first write
      i_rst_b <= 1'b0;
      idle(2);
      i_rst_b <= 1'b1;
      i_osc_stable <= 1'b1;
      use_fixed <= 1'b1;
      wr(C1, c1(1'b1, 1'b0, 1'b1, 2'h3));
      rd(S1, r);
      `CHK(r[7:6], 2'h0);
      idle(40);
      rd(S1, r);
      `CHK({o_high_gain_select, r[7:6]}, 3'h7);
      window(240);
      `CHK(near(d[4], d[0] / 2) && near(d_fix, d[1]), 1'b1);
      i_lock <= 1'b1;
      idle(4);
      window(240);
      `CHK(near(d[4], d[0]) && near(d_fix, d[3] / 2), 1'b1);
      wr(C1, c1(1'b1, 1'b1, 1'b1, 2'h3));
      idle(40);
      for (int k = 0; k < 4; k++) begin
         wr(C2, {1'b0, MT[k], 1'b0, DT[k]});
         idle(4);
         window(240);
         `CHK(near(d_fix, half_ok(1'b1, MT[k], DT[k]) ? d[3] / 2 : d[1]), 1'b1);
      end
      wr(C1, c1(1'b1, 1'b1, 1'b1, 2'h1));
      rd(S1, r);
      `CHK(r[7:6], 2'h3);
      `CHK(o_osc_amp_enable, 1'b0);
      wr(C1, c1(1'b0, 1'b1, 1'b1, 2'h2));
      idle(40);
      rd(S1, r);
      `CHK({o_osc_amp_enable, o_high_gain_select, r[7:6]}, 4'ha);
      window(240);
      `CHK(near(d_fix, d[1]), 1'b1);
      i_osc_stable <= 1'b0;
      wr(C1, c1(1'b0, 1'b1, 1'b1, 2'h0));
      idle(40);
      rd(S1, r);
      `CHK(r[7:6], 2'h2);
      i_osc_stable <= 1'b1;
      idle(20);
      rd(S1, r);
      `CHK(r[7:6], 2'h0);
      use_fixed <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         wr(C2, 8'(k));
         idle(4);
         window(240);
         `CHK(near(d[4], d[0] >> k), 1'b1);
      end
      `CHK(near(d[5], d[2] / 8), 1'b1);
      i_off_state <= 1'b1;
      idle(2);
      window(40);
      `CHK(d[4], 0);
      i_off_state <= 1'b0;
      prev = 2'h0;
      old_rq = 2'h0;
      for (int k = 0; k < 16; k++) begin
         rq = 2'($urandom % 4);
         {i_osc_stable, i_ext_ref_valid, i_loss_of_clock_flag, i_lock} <= 4'($urandom);
         wr(C1, c1(1'b0, 1'b0, 1'b1, rq));
         idle(40);
         rd(S1, r);
         prev = exp_mode(old_rq, prev, i_osc_stable, i_ext_ref_valid, i_loss_of_clock_flag);
         prev = exp_mode(rq, prev, i_osc_stable, i_ext_ref_valid, i_loss_of_clock_flag);
         old_rq = rq;
         `CHK(r[7:6], prev);
      end
      complete_run();
   end
   initial begin
      idle(30000);
      num_errors++;
      complete_run();
   end
endmodule
`default_nettype wire
